/* File: bench/mbi_monitor.sv */
// Checker for the core-side ports and pin enables of the two-wire interface.
`timescale 1ns/10ps
module mbi_monitor (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Controls
  input wire logic       interface_hold_reset,
  input wire logic [1:0] line_pair_select,
  input wire logic       extra_checks_enable,
  input wire logic       data_wr,
  // Status and pins
  input wire logic       irq_pending_flag,
  input wire logic       error_flag,
  input wire logic       stale_byte_flag,
  input wire logic       contention_loss_flag,
  input wire logic       bus_active_flag,
  input wire logic       master_flag,
  input wire logic [3:0] scl_oe,
  input wire logic [3:0] sda_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Eight cycles cover both synchronisers, so the held state has settled.
  sequence s_held; interface_hold_reset [*8]; endsequence
  sequence s_go; data_wr && !interface_hold_reset && !bus_active_flag && !irq_pending_flag;
  endsequence
  sequence s_ack; data_wr && irq_pending_flag && !interface_hold_reset; endsequence
  a_hold_quiet: assert property (s_held |-> !irq_pending_flag && !master_flag)
    else $error("core active while held");
  a_hold_pins: assert property (s_held |-> (scl_oe | sda_oe) == 4'h0)
    else $error("pins driven while held");
  a_start_master: assert property (s_go |-> ##[1:60] master_flag)
    else $error("no master role after write");
  a_wr_clears_irq: assert property (s_ack |=> !irq_pending_flag)
    else $error("interrupt kept after write");
  a_wr_clears_err: assert property (s_ack |=> !error_flag && !contention_loss_flag)
    else $error("error flags kept after write");
  a_err_irq: assert property ($rose(error_flag) |-> ##[0:4] irq_pending_flag)
    else $error("error without interrupt");
  a_arb_irq: assert property ($rose(contention_loss_flag) |-> ##[0:4] irq_pending_flag)
    else $error("arbitration loss without interrupt");
  a_class_gated: assert property ($rose(stale_byte_flag) |-> extra_checks_enable)
    else $error("class flag without extra checks");
  a_pair_only: assert property (!interface_hold_reset && $stable(line_pair_select)
    |-> ((scl_oe | sda_oe) & ~(4'h1 << line_pair_select)) == 4'h0)
    else $error("unselected pair driven");
endmodule // mbi_monitor
bind mbi_iface mbi_monitor mon_u (.clk, .sys_rst, .interface_hold_reset, .line_pair_select,
  .extra_checks_enable, .data_wr, .irq_pending_flag, .error_flag, .stale_byte_flag,
  .contention_loss_flag, .bus_active_flag, .master_flag, .scl_oe, .sda_oe);

/* File: bench/mbi_peer.sv */
// Behavioural slave device: acknowledges its address and answers a read with one byte.
`timescale 1ns/10ps
module mbi_peer (
  // Bus levels
  input wire logic       scl,
  input wire logic       sda,
  // Setup and result
  input wire logic [6:0] match_addr,
  output logic           sda_pull,
  output logic     [7:0] rx
);
  int         cnt  = 9;
  logic       on   = 0;
  logic       send = 0;
  logic [7:0] tx   = 8'h00;
  initial sda_pull = 0;
  initial rx = 8'h00;
  always @(negedge sda) if (scl) begin
    cnt = 0;
    on = 1;
    send = 0;
  end
  always @(posedge sda) if (scl) begin
    on = 0;
    send = 0;
  end
  always @(posedge scl) if (on && !send && cnt < 8) begin
    rx = {rx[6:0], sda};
    cnt++;
  end
  // A read is answered with the inverted address, one bit per low phase of the clock.
  always @(negedge scl) begin
    if (send && cnt < 8) begin
      sda_pull = !tx[7 - cnt];
      cnt++;
    end else if (send) begin
      sda_pull = 0;
      send = 0;
      cnt = 9;
    end else if (on && cnt == 8 && !sda_pull && rx[7:1] == match_addr) sda_pull = 1;
    else if (sda_pull) begin
      send = rx[0];
      tx = ~rx;
      sda_pull = rx[0] && rx[7];
      cnt = rx[0] ? 1 : 9;
    end
  end
endmodule // mbi_peer

/* File: bench/tb.sv */
// Self-checking bench: master address phases on all four pin pairs, a read byte on pair 2.
`timescale 1ns/10ps
module tb;
  import mbi_pkg::*;
  logic clk = 0, link_clk = 0, sys_rst = 1, hold = 1, data_wr = 0, stop_req = 0;
  logic [1:0] pair = 2'h0;
  logic [3:0] div = 4'h0, scl_o, scl_oe, sda_o, sda_oe, scl_w, sda_w;
  logic [6:0] cfg = 7'h00;
  logic [7:0] own = 8'h00, wdata = 8'h00, addr, shift_data, peer_rx;
  logic irq, peer_pull, address_byte_flag, broadcast_seen_flag, slave_engaged_flag;
  logic read_dir_flag, ack_received_flag, error_flag, stale_byte_flag, bus_active_flag;
  logic surprise_condition_flag, wrong_position_flag, contention_loss_flag, master_flag;
  int n_errors = 0, checks = 0;
  logic [7:0] exp_q[$];
  logic [7:0] role, errs;
  assign role = {2'b00, master_flag, ack_received_flag, address_byte_flag, read_dir_flag,
                 slave_engaged_flag, broadcast_seen_flag};
  assign errs = {3'b000, error_flag, stale_byte_flag, surprise_condition_flag,
                 wrong_position_flag, contention_loss_flag && !error_flag};
  always #5 clk = ~clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // Open-drain lines with pull-ups; the peer sits on pair 2 only.
  assign scl_w = ~scl_oe;
  assign sda_w = ~sda_oe & ~{1'b0, peer_pull, 2'b00};
  mbi_iface dut_u (.*, .interface_hold_reset(hold), .own_slave_address(own),
    .bus_clock_divider(div), .line_pair_select(pair), .partial_match_select(cfg[0]),
    .broadcast_ack_select(cfg[1]), .ack_suppress(cfg[2]), .stop_irq_enable(cfg[3]),
    .glitch_filter_enable(cfg[4]), .auto_restart_enable(cfg[5]),
    .extra_checks_enable(cfg[6]), .data_wdata(wdata), .irq_pending_flag(irq),
    .scl_i(scl_w), .sda_i(sda_w));
  mbi_peer peer_u (.scl(scl_w[2]), .sda(sda_w[2]), .match_addr(addr[7:1]),
    .sda_pull(peer_pull), .rx(peer_rx));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic write(input logic [7:0] d, input logic stop);
    @(negedge clk);
    data_wr = 1;
    wdata = d;
    stop_req = stop;
    @(negedge clk);
    data_wr = 0;
    stop_req = 0;
  endtask
  task automatic wait_on(input bit idle);
    int i;
    for (i = 0; i < 20000; i++) begin
      if (idle ? bus_active_flag === 1'b0 : irq === 1'b1) break;
      @(negedge clk);
    end
    if (i == 20000) n_errors++;
  endtask
  initial begin
    #400_000;
    n_errors++;
    finish_test;
  end
  initial begin
    addr = $urandom(32'h5E40F16F);
    own = {1'b0, 7'($urandom)};
    cfg = 7'($urandom) & 7'h53;
    repeat (6) @(negedge clk);
    sys_rst = 0;
    repeat (10) @(negedge clk);
    chk({irq, master_flag, scl_oe, sda_oe[1:0]}, 8'h00);
    chk({scl_o, sda_o}, 8'h00);
    hold = 0;
    repeat (6) @(negedge clk);
    for (int p = 0; p < 4; p++) begin
      pair = 2'(p);
      addr = {~own[7:4], 3'($urandom), p == 2};
      exp_q.push_back(addr);
      repeat (4) @(negedge clk);
      write(addr, 1'b0);
      wait_on(1'b0);
      chk(shift_data, exp_q.pop_front());
      if (p == 2) chk(peer_rx, addr);
      chk(role, {2'b00, 1'b1, p == 2, 1'b1, p == 2, 2'b00});
      chk(errs, 8'h00);
      if (p == 2) begin
        cfg[2] = 1'b1;
        exp_q.push_back(~addr);
        write(8'h00, 1'b0);
        wait_on(1'b0);
        chk(shift_data, exp_q.pop_front());
        chk(role, 8'h24);
        cfg[2] = 1'b0;
      end
      write(8'h00, 1'b1);
      wait_on(1'b1);
      chk(8'({master_flag, irq}), 8'h00);
    end
    finish_test;
  end
endmodule // tb

/* File: logic/mbi_iface.sv */
// Two-wire serial master/slave interface with four selectable pin pairs.
`timescale 1ns/10ps
// Behaviour
// - Interface stays in reset while interface_hold_reset is one.
// - Idle as inactive slave; becomes master only when it starts a sequence.
// - After a start, shift in address; compare 7 or 4 upper bits and broadcast.
// - Unmatched address is ignored until the next start condition.
// - Ack broadcast if broadcast_ack_select, own address if ack_suppress clear; then interrupt.
// - Report address byte, broadcast seen, slave engaged and direction.
// - Slave receiver stores byte, acks per ack_suppress, then interrupts.
// - Slave transmitter sends data byte; after ack clock interrupts and records ack.
// - A stop condition returns the interface to inactive slave.
// - With stop_irq_enable, a stop condition raises an interrupt.
// - Data write on free bus makes master, sends start and byte, interrupts at ninth clock.
// - With auto_restart_enable, next data write produces a repeated start.
// - Master receiver stores byte, acks per ack_suppress, then interrupts.
// - Master transmitter sends byte; on ack bit interrupts and updates ack_received_flag.
// - A stop request in master mode generates a stop condition.
// - Any data write acknowledges the pending interrupt.
// - Illegal start or stop sets error_flag and interrupts.
// - With extra_checks_enable, illegal conditions are classified into two flags.
// - Arbitration loss sets contention_loss_flag and interrupts.
// - Bytes move MSB first; a ninth clock carries the receiver acknowledge.
// - line_pair_select picks one of four clock/data pin pairs.
module mbi_iface (
  // Clocks and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     link_clk,
  // Configuration levels
  input  wire logic                     interface_hold_reset,
  input  wire logic [7:0]               own_slave_address,
  input  wire logic [3:0]               bus_clock_divider,
  input  wire logic [1:0]               line_pair_select,
  input  wire logic                     partial_match_select,
  input  wire logic                     broadcast_ack_select,
  input  wire logic                     ack_suppress,
  input  wire logic                     stop_irq_enable,
  input  wire logic                     glitch_filter_enable,
  input  wire logic                     auto_restart_enable,
  input  wire logic                     extra_checks_enable,
  // Software strobes
  input  wire logic                     data_wr,
  input  wire logic [mbi_pkg::DW-1:0]   data_wdata,
  input  wire logic                     stop_req,
  // Status
  output logic      [mbi_pkg::DW-1:0]   shift_data,
  output logic                          irq_pending_flag,
  output logic                          address_byte_flag,
  output logic                          broadcast_seen_flag,
  output logic                          slave_engaged_flag,
  output logic                          read_dir_flag,
  output logic                          ack_received_flag,
  output logic                          error_flag,
  output logic                          stale_byte_flag,
  output logic                          surprise_condition_flag,
  output logic                          wrong_position_flag,
  output logic                          contention_loss_flag,
  output logic                          bus_active_flag,
  output logic                          master_flag,
  // Bus pins, open drain
  input  wire logic [mbi_pkg::NPAIR-1:0] scl_i,
  output logic      [mbi_pkg::NPAIR-1:0] scl_o,
  output logic      [mbi_pkg::NPAIR-1:0] scl_oe,
  input  wire logic [mbi_pkg::NPAIR-1:0] sda_i,
  output logic      [mbi_pkg::NPAIR-1:0] sda_o,
  output logic      [mbi_pkg::NPAIR-1:0] sda_oe
);
  import mbi_pkg::*;

  function automatic logic [NPAIR-1:0] pair_dec(input logic [1:0] sel, input logic en);
    pair_dec = en ? (NPAIR'(1) << sel) : '0;
  endfunction

  // ****************************************
  // Core side: command toward the link
  // ****************************************
  logic          cmd_tgl_reg;
  logic [DW-1:0] cmd_data_reg;
  logic          cmd_stop_reg;
  logic          cmd_rs_reg;
  logic          stop_pend_reg;
  logic          busy_c1, busy_c2, mst_c1, mst_c2;

  // A write on a busy bus with nothing pending is dropped, so that a stale
  // command can never be taken later as the answer to a slave byte.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_tgl_reg  <= 1'b0;
      cmd_data_reg <= DATA_RST;
      cmd_stop_reg <= 1'b0;
      cmd_rs_reg   <= 1'b0;
    end else if (data_wr && !interface_hold_reset && (irq_pending_flag || !busy_c2)) begin
      cmd_tgl_reg  <= ~cmd_tgl_reg;
      cmd_data_reg <= data_wdata;
      cmd_stop_reg <= stop_pend_reg || stop_req;
      cmd_rs_reg   <= auto_restart_enable;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stop_pend_reg <= 1'b0;
    end else if (interface_hold_reset || data_wr) begin
      stop_pend_reg <= 1'b0;
    end else if (stop_req) begin
      stop_pend_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_c1 <= 1'b0;
      busy_c2 <= 1'b0;
      mst_c1  <= 1'b0;
      mst_c2  <= 1'b0;
    end else begin
      busy_c1 <= busy_l;
      busy_c2 <= busy_c1;
      mst_c1  <= master_l;
      mst_c2  <= mst_c1;
    end
  end
  assign bus_active_flag = busy_c2;
  assign master_flag     = mst_c2;

  // ****************************************
  // Core side: events from the link
  // ****************************************
  logic          ev_tgl_l;
  logic [3:0]    ev_kind_l;
  logic [DW-1:0] ev_data_l;
  logic          ev_ack_l, ev_addr_l, ev_gc_l, ev_read_l, ev_mst_l, ev_cls_l;
  logic          ev_s1, ev_s2, ev_s3;
  logic          ev_fire;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_s1 <= 1'b0;
      ev_s2 <= 1'b0;
      ev_s3 <= 1'b0;
    end else begin
      ev_s1 <= ev_tgl_l;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
    end
  end
  assign ev_fire = (ev_s2 ^ ev_s3) && !interface_hold_reset;

  logic ev_irq;
  assign ev_irq = ev_fire && (ev_kind_l[EV_BYTE] || ev_kind_l[EV_ERR] || ev_kind_l[EV_ARB] ||
                             (ev_kind_l[EV_STOP] && stop_irq_enable));

  // Set wins over the clearing data write.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_pending_flag <= 1'b0;
    end else if (interface_hold_reset) begin
      irq_pending_flag <= 1'b0;
    end else if (ev_irq) begin
      irq_pending_flag <= 1'b1;
    end else if (data_wr) begin
      irq_pending_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_data          <= DATA_RST;
      address_byte_flag   <= 1'b0;
      broadcast_seen_flag <= 1'b0;
      slave_engaged_flag  <= 1'b0;
      read_dir_flag       <= 1'b0;
      ack_received_flag   <= 1'b0;
    end else if (interface_hold_reset) begin
      shift_data          <= DATA_RST;
      address_byte_flag   <= 1'b0;
      broadcast_seen_flag <= 1'b0;
      slave_engaged_flag  <= 1'b0;
      read_dir_flag       <= 1'b0;
      ack_received_flag   <= 1'b0;
    end else if (ev_fire && ev_kind_l[EV_BYTE]) begin
      shift_data          <= ev_data_l;
      address_byte_flag   <= ev_addr_l;
      broadcast_seen_flag <= ev_gc_l;
      slave_engaged_flag  <= !ev_mst_l;
      read_dir_flag       <= ev_read_l;
      ack_received_flag   <= ev_ack_l;
    end else if (ev_fire && (ev_kind_l[EV_STOP] || ev_kind_l[EV_ERR] || ev_kind_l[EV_ARB])) begin
      slave_engaged_flag  <= 1'b0;
    end
  end

  // With extra_checks_enable, a byte arriving while the previous interrupt is unanswered counts as stale.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      error_flag              <= 1'b0;
      stale_byte_flag         <= 1'b0;
      surprise_condition_flag <= 1'b0;
      wrong_position_flag     <= 1'b0;
      contention_loss_flag    <= 1'b0;
    end else if (interface_hold_reset) begin
      error_flag              <= 1'b0;
      stale_byte_flag         <= 1'b0;
      surprise_condition_flag <= 1'b0;
      wrong_position_flag     <= 1'b0;
      contention_loss_flag    <= 1'b0;
    end else begin
      // Each flag decides set against clear on its own, so an unrelated event
      // in the cycle of a data write cannot keep a stale flag alive.
      if (ev_fire && ev_kind_l[EV_ERR]) begin
        error_flag <= 1'b1;
      end else if (data_wr) begin
        error_flag <= 1'b0;
      end
      if (ev_fire && ev_kind_l[EV_BYTE] && irq_pending_flag && extra_checks_enable) begin
        stale_byte_flag <= 1'b1;
      end else if (data_wr) begin
        stale_byte_flag <= 1'b0;
      end
      if (ev_fire && ev_kind_l[EV_ERR] && extra_checks_enable && ev_cls_l == EC_SURP) begin
        surprise_condition_flag <= 1'b1;
      end else if (data_wr) begin
        surprise_condition_flag <= 1'b0;
      end
      if (ev_fire && ev_kind_l[EV_ERR] && extra_checks_enable && ev_cls_l == EC_WPOS) begin
        wrong_position_flag <= 1'b1;
      end else if (data_wr) begin
        wrong_position_flag <= 1'b0;
      end
      if (ev_fire && ev_kind_l[EV_ARB]) begin
        contention_loss_flag <= 1'b1;
      end else if (data_wr) begin
        contention_loss_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // Link side: synchronisers
  // ****************************************
  logic [CFG_W-1:0] cfg_s1, cfg_s2;
  logic             hold_s1, hold_s2, cmd_s1, cmd_s2;
  logic [NPAIR-1:0] scl_s1, scl_s2, sda_s1, sda_s2;

  // Configuration is quasi-static: software changes it only between bytes.
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_s1  <= '0;
      cfg_s2  <= '0;
      hold_s1 <= 1'b1;
      hold_s2 <= 1'b1;
      cmd_s1  <= 1'b0;
      cmd_s2  <= 1'b0;
      scl_s1  <= '1;
      scl_s2  <= '1;
      sda_s1  <= '1;
      sda_s2  <= '1;
    end else begin
      cfg_s1  <= {own_slave_address[7:1], partial_match_select, broadcast_ack_select,
                  ack_suppress, glitch_filter_enable, bus_clock_divider, line_pair_select};
      cfg_s2  <= cfg_s1;
      hold_s1 <= interface_hold_reset;
      hold_s2 <= hold_s1;
      cmd_s1  <= cmd_tgl_reg;
      cmd_s2  <= cmd_s1;
      scl_s1  <= scl_i;
      scl_s2  <= scl_s1;
      sda_s1  <= sda_i;
      sda_s2  <= sda_s1;
    end
  end

  logic [6:0] c_own;
  logic       c_psel, c_bcack, c_acksup, c_filt;
  logic [3:0] c_div;
  logic [1:0] c_lsel;
  logic [DIV_W-1:0] half_cyc;
  assign {c_own, c_psel, c_bcack, c_acksup, c_filt, c_div, c_lsel} = cfg_s2;
  assign half_cyc = DIV_W'((32'(c_div) + 32'd1) * HALF_UNIT_CYC);

  // ****************************************
  // Link side: pin filter and conditions
  // ****************************************
  logic scl_d, sda_d, scl_f, sda_f, scl_p, sda_p;
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_d <= scl_s2[c_lsel];
      sda_d <= sda_s2[c_lsel];
      // A level change is accepted only once two samples agree.
      if (!c_filt || scl_s2[c_lsel] == scl_d) begin
        scl_f <= scl_s2[c_lsel];
      end
      if (!c_filt || sda_s2[c_lsel] == sda_d) begin
        sda_f <= sda_s2[c_lsel];
      end
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  logic start_det, stop_det, scl_rise, scl_fall;
  assign start_det = scl_f && scl_p && sda_p && !sda_f;
  assign stop_det  = scl_f && scl_p && !sda_p && sda_f;
  assign scl_rise  = scl_f && !scl_p;
  assign scl_fall  = !scl_f && scl_p;

  // ****************************************
  // Link side: byte engine
  // ****************************************
  mbi_state_t       st;
  logic [3:0]       bitcnt;
  logic [DW-1:0]    shreg;
  logic [DIV_W-1:0] dcnt;
  logic             cmd_seen, scl_low, sda_low, tx_l, master_l, busy_l;
  logic             rd_l, addr_l, gc_l, ack_in;
  logic             gc_hit, own_hit, illegal;

  assign gc_hit  = shreg[7:1] == BCAST_ADDR;
  assign own_hit = c_psel ? (shreg[7:4] == c_own[6:3]) : (shreg[7:1] == c_own);
  assign illegal = (start_det || stop_det) &&
                   ((st == ST_BYTE && bitcnt != 4'h0) || st == ST_ACK);

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_l <= 1'b0;
    end else if (hold_s2 || stop_det) begin
      busy_l <= 1'b0;
    end else if (start_det) begin
      busy_l <= 1'b1;
    end
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= ST_IDLE; bitcnt <= 4'h0; shreg <= DATA_RST; dcnt <= '0;
      cmd_seen <= 1'b0; scl_low <= 1'b0; sda_low <= 1'b0; tx_l <= 1'b0;
      master_l <= 1'b0; rd_l <= 1'b0; addr_l <= 1'b0; gc_l <= 1'b0; ack_in <= 1'b0;
      ev_tgl_l <= 1'b0; ev_kind_l <= 4'h0; ev_data_l <= DATA_RST; ev_ack_l <= 1'b0;
      ev_addr_l <= 1'b0; ev_gc_l <= 1'b0; ev_read_l <= 1'b0; ev_mst_l <= 1'b0;
      ev_cls_l <= EC_WPOS;
    end else if (hold_s2) begin
      st <= ST_IDLE; scl_low <= 1'b0; sda_low <= 1'b0;
      master_l <= 1'b0; cmd_seen <= cmd_s2;
    end else if (illegal) begin
      st <= ST_IDLE; scl_low <= 1'b0; sda_low <= 1'b0; master_l <= 1'b0;
      ev_kind_l <= 4'h1 << EV_ERR; ev_cls_l <= (st == ST_ACK) ? EC_SURP : EC_WPOS;
      ev_tgl_l <= ~ev_tgl_l;
    end else if (stop_det) begin
      st <= ST_IDLE; scl_low <= 1'b0; sda_low <= 1'b0; master_l <= 1'b0;
      ev_kind_l <= 4'h1 << EV_STOP;
      ev_tgl_l <= ~ev_tgl_l;
    end else if (start_det && st != ST_START) begin
      st <= ST_BYTE; bitcnt <= 4'h0; tx_l <= 1'b0; addr_l <= 1'b1;
      master_l <= 1'b0; scl_low <= 1'b0; sda_low <= 1'b0;
    end else begin
      if (dcnt != '0 && (scl_low || scl_f)) begin
        dcnt <= dcnt - DIV_W'(1);
      end
      case (st)
        ST_IDLE: begin
          if (cmd_s2 != cmd_seen && !busy_l) begin
            cmd_seen <= cmd_s2;
            st <= ST_START; master_l <= 1'b1; sda_low <= 1'b1; dcnt <= half_cyc;
            shreg <= cmd_data_reg; tx_l <= 1'b1; addr_l <= 1'b1; rd_l <= cmd_data_reg[0];
          end
        end
        ST_RSTART: begin
          if (dcnt == '0 && scl_low) begin
            scl_low <= 1'b0; dcnt <= half_cyc;
          end else if (dcnt == '0 && scl_f) begin
            st <= ST_START; sda_low <= 1'b1; dcnt <= half_cyc;
          end
        end
        ST_START: begin
          if (dcnt == '0) begin
            st <= ST_BYTE; scl_low <= 1'b1; dcnt <= half_cyc; bitcnt <= 4'h0;
          end
        end
        ST_BYTE, ST_ACK: begin
          // The master makes the bus clock and waits while a slave stretches it.
          if (master_l && dcnt == '0) begin
            if (scl_low) begin
              scl_low <= 1'b0; dcnt <= half_cyc;
            end else if (scl_f) begin
              scl_low <= 1'b1; dcnt <= half_cyc;
            end
          end
          if (st == ST_BYTE && scl_rise) begin
            if (master_l && tx_l && shreg[7] && !sda_f) begin
              st <= ST_IDLE; master_l <= 1'b0; scl_low <= 1'b0; sda_low <= 1'b0;
              ev_kind_l <= 4'h1 << EV_ARB; ev_tgl_l <= ~ev_tgl_l;
            end else begin
              shreg <= {shreg[6:0], sda_f};
              bitcnt <= bitcnt + 4'h1;
            end
          end else if (st == ST_BYTE && scl_fall) begin
            if (bitcnt != 4'(BIT_ACK)) begin
              sda_low <= tx_l && !shreg[7];
            end else if (addr_l && !master_l) begin
              if (gc_hit ? c_bcack : (own_hit && !c_acksup)) begin
                st <= ST_ACK; sda_low <= 1'b1; gc_l <= gc_hit;
                rd_l <= shreg[0];
              end else begin
                st <= ST_IDLE; sda_low <= 1'b0;
              end
            end else begin
              st <= ST_ACK; sda_low <= !tx_l && !c_acksup;
              gc_l <= addr_l ? 1'b0 : gc_l;
            end
          end else if (st == ST_ACK && scl_rise) begin
            ack_in <= !sda_f;
          end else if (st == ST_ACK && scl_fall) begin
            // Stretch the clock until software answers the interrupt.
            st <= ST_HOLD; scl_low <= 1'b1; sda_low <= 1'b0; bitcnt <= 4'h0;
            if (addr_l) begin
              tx_l <= master_l ? !rd_l : rd_l;
            end
            addr_l <= 1'b0;
            ev_kind_l <= 4'h1 << EV_BYTE; ev_data_l <= shreg; ev_ack_l <= ack_in;
            ev_addr_l <= addr_l; ev_gc_l <= gc_l; ev_read_l <= rd_l;
            ev_mst_l <= master_l; ev_tgl_l <= ~ev_tgl_l;
          end
        end
        ST_HOLD: begin
          if (cmd_s2 != cmd_seen) begin
            cmd_seen <= cmd_s2;
            if (master_l && cmd_stop_reg) begin
              st <= ST_STOP; sda_low <= 1'b1; dcnt <= half_cyc;
            end else if (master_l && cmd_rs_reg) begin
              st <= ST_RSTART; dcnt <= half_cyc; shreg <= cmd_data_reg;
              tx_l <= 1'b1; addr_l <= 1'b1; rd_l <= cmd_data_reg[0];
            end else begin
              st <= ST_BYTE;
              if (tx_l) begin
                shreg <= cmd_data_reg;
              end
              sda_low <= tx_l && !cmd_data_reg[7];
              scl_low <= master_l;
              dcnt <= half_cyc;
            end
          end
        end
        ST_STOP: begin
          if (dcnt == '0 && scl_low) begin
            scl_low <= 1'b0; dcnt <= half_cyc;
          end else if (dcnt == '0 && scl_f) begin
            sda_low <= 1'b0;
          end
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Link side: pin drivers
  // ****************************************
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_oe <= '0;
      sda_oe <= '0;
    end else begin
      scl_oe <= pair_dec(c_lsel, scl_low && !hold_s2);
      sda_oe <= pair_dec(c_lsel, sda_low && !hold_s2);
    end
  end
  assign scl_o = '0;
  assign sda_o = '0;
endmodule // mbi_iface

/* File: shared/mbi_pkg.sv */
// Shared constants and types for the multi-bus two-wire serial interface.
package mbi_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int DW      = 8;
  localparam int NPAIR   = 4;
  localparam int BIT_ACK = 8;
  localparam int CFG_W   = 17;
  localparam int DIV_W   = 12;

  // ****************************************
  // Addresses and reset values
  // ****************************************
  localparam logic [6:0] BCAST_ADDR = 7'h00;
  localparam logic [7:0] DATA_RST   = 8'h00;

  // ****************************************
  // Bus timing, link clock of 6 ns
  // ****************************************
  localparam int LINK_PERIOD_NS = 6;
  localparam int HALF_UNIT_NS   = 1000;
  localparam int HALF_UNIT_CYC  = (HALF_UNIT_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

  // ****************************************
  // Event kinds and error classes
  // ****************************************
  localparam int EV_BYTE = 0;
  localparam int EV_ERR  = 1;
  localparam int EV_ARB  = 2;
  localparam int EV_STOP = 3;
  localparam logic EC_WPOS = 1'b0;
  localparam logic EC_SURP = 1'b1;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_START  = 7'h02,
    ST_BYTE   = 7'h04,
    ST_ACK    = 7'h08,
    ST_HOLD   = 7'h10,
    ST_STOP   = 7'h20,
    ST_RSTART = 7'h40
  } mbi_state_t;
endpackage
